// ---- rtl/bridge_ctl_if.sv ----
// Interface: register port between the controlling master end and the
// control bank. Read data stand the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
interface bridge_ctl_if;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        hold_granted;
    modport dev  (input addr, input wdata, input wr, input rd,
                  output rdata, output hold_granted);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata, input hold_granted);
endinterface
`default_nettype wire

// ---- rtl/bridge_ctl_master.sv ----
// Controlling master end: forwards software register accesses to the
// control bank, refusing the writes that masters must never make.
// Assumes read data arrive from the bank the cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module bridge_ctl_master
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    bridge_ctl_if.host        bus,
    input  wire logic [11:0]  i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    input  wire logic         i_from_vme,
    input  wire logic         i_berr,
    output logic [31:0]       o_rdata,
    output logic              o_refused
);
    typedef struct packed {
        logic [31:0] mc_shadow;
        logic        berr_pending;
        logic        refused;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic   is_mc;
    logic   is_misc;
    logic   bad_wr;
    logic   hold_set;

    assign is_mc    = (i_addr == bridge_ctl_pkg::MASTER_CONTROL_ADDR);
    assign is_misc  = (i_addr == bridge_ctl_pkg::MISC_CONTROL_ADDR);
    assign hold_set = i_wdata[bridge_ctl_pkg::HOLD_REQ_BIT];
    // Refuse whole writes that would break the bus rules
    assign bad_wr = i_wr && (
        (is_mc && hold_set && bus.hold_granted)   // RULE10
        || (is_mc && hold_set && i_from_vme)      // RULE12
        || (is_misc && i_from_vme
            && i_wdata[bridge_ctl_pkg::SOFT_SYSRST_BIT])  // RULE19
        || (is_misc && !i_from_vme
            && i_wdata[bridge_ctl_pkg::LOCAL_RST_BIT]));  // RULE19

    // Bus drive; a pending hold release takes idle cycles only
    always_comb
    begin
        bus.addr  = i_addr;
        bus.wdata = i_wdata;
        bus.rd    = i_rd;
        bus.wr    = i_wr && !bad_wr;
        if (!i_wr && !i_rd && s_reg.berr_pending)
        begin
            bus.addr  = bridge_ctl_pkg::MASTER_CONTROL_ADDR;
            bus.wdata = s_reg.mc_shadow;
            bus.wdata[bridge_ctl_pkg::HOLD_REQ_BIT] = 1'b0;  // RULE11
            bus.wr    = 1'b1;
        end
    end

    // Shadow of master_control so a release keeps other fields
    always_comb
    begin
        s_next = s_reg;
        s_next.refused = bad_wr;
        if (bus.wr && bus.addr == bridge_ctl_pkg::MASTER_CONTROL_ADDR)
        begin
            s_next.mc_shadow = bus.wdata;
            if (!bus.wdata[bridge_ctl_pkg::HOLD_REQ_BIT])
            begin
                s_next.berr_pending = 1'b0;
            end
        end
        // Bus error wins over a same-cycle clear
        if (i_berr && s_reg.mc_shadow[bridge_ctl_pkg::HOLD_REQ_BIT]
            && bus.hold_granted)
        begin
            s_next.berr_pending = 1'b1;  // RULE11
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_rdata   = bus.rdata;
    assign o_refused = s_reg.refused;
endmodule // bridge_ctl_master
`default_nettype wire

// ---- rtl/bridge_ctl_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
// of the bridge master/misc control bank. Shared by both ends.
package bridge_ctl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] MASTER_CONTROL_ADDR = 12'h400;
    localparam logic [11:0] MISC_CONTROL_ADDR   = 12'h404;
    // master_control field positions
    localparam int RETRY_LIMIT_LSB  = 28;
    localparam int TENURE_LSB       = 24;
    localparam int REQ_LEVEL_LSB    = 22;
    localparam int FAIRNESS_BIT     = 21;
    localparam int RELEASE_BIT      = 20;
    localparam int HOLD_REQ_BIT     = 19;
    localparam int HOLD_GRANTED_BIT = 18;
    localparam int BURST_LSB        = 12;
    localparam int BUS_NO_LSB       = 0;
    // misc_control field positions
    localparam int BUS_TO_LSB       = 28;
    localparam int ARB_POLICY_BIT   = 26;
    localparam int ARB_TO_LSB       = 24;
    localparam int LOCAL_RST_BIT    = 23;
    localparam int SOFT_SYSRST_BIT  = 22;
    localparam int ISOLATION_BIT    = 20;
    localparam int GLOBAL_ISO_BIT   = 19;
    localparam int RESCIND_BIT      = 18;
    localparam int SYS_CTRL_BIT     = 17;
    localparam int AUTO_ID_BIT      = 16;
    localparam int SYSRST_TRIG_BIT  = 14;
    // Reset values
    localparam logic [3:0] RETRY_LIMIT_RST = 4'h8;
    localparam logic [3:0] TENURE_RST      = 4'h0;
    localparam logic [1:0] REQ_LEVEL_RST   = 2'h3;
    localparam logic [3:0] BUS_TO_RST      = 4'h3;
    localparam logic [1:0] ARB_TO_RST      = 2'h1;
    // Code values
    localparam logic [3:0] RETRY_FOREVER   = 4'h0;
    localparam logic [3:0] TENURE_MAX_CODE = 4'h5;
    localparam logic [3:0] TENURE_EARLY    = 4'hF;
    localparam logic [3:0] BUS_TO_MAX_CODE = 4'h7;
    localparam logic [1:0] ARB_TO_SHORT    = 2'h1;
    localparam logic [1:0] ARB_TO_LONG     = 2'h2;
    localparam int RETRY_UNIT_SHIFT  = 6;   // multiples of 64
    localparam logic [12:0] TENURE_BASE_BYTES = 13'h0080;  // 128 bytes
    localparam logic [8:0]  BURST_BASE_BYTES  = 9'h020;    // 32 bytes
    // Timing, 40 MHz clock
    localparam int CLK_PERIOD_NS    = 25;
    localparam int BUS_TO_BASE_NS   = 16000;   // 16 us
    localparam int ARB_TO_SHORT_NS  = 16000;   // 16 us
    localparam int ARB_TO_LONG_NS   = 256000;  // 256 us
    localparam int BUS_TO_BASE_CYC  = BUS_TO_BASE_NS / CLK_PERIOD_NS;
    localparam int ARB_TO_SHORT_CYC = ARB_TO_SHORT_NS / CLK_PERIOD_NS;
    localparam int ARB_TO_LONG_CYC  = ARB_TO_LONG_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_W        = 17;
    // Auto slot-ID sequence, Gray coded
    typedef enum logic [1:0] {
        AUTO_IDLE = 2'b00,
        AUTO_IRQ  = 2'b01,
        AUTO_WAIT = 2'b11,
        AUTO_DONE = 2'b10
    } auto_state_t;
endpackage

// ---- rtl/bridge_ctl_regs.sv ----
// Control bank of the bridge: master_control and misc_control registers
// and the control levels and pulses they drive into the bridge logic.
// Assumes one clock, synchronous active-high reset, straps stable.
// Functional notes
// RULE1 - retry limit resets 8; zero means forever
// RULE2 - tenure codes 128..4096 bytes, 1111 early
// RULE3 - early bus-busy release at tenure or transaction
// RULE4 - two-bit request level, resets to three
// RULE5 - request mode bit: demand or fair
// RULE6 - release policy: when done or on request
// RULE7 - bus hold bit keeps bus busy asserted
// RULE8 - hold granted reads one while held
// RULE9 - no early release while bus held
// RULE10 - software waits granted zero before hold
// RULE11 - on bus error, software clears hold
// RULE12 - VME masters never set hold bit
// RULE13 - burst field sets split boundary, threshold
// RULE14 - config type 0 when bus number matches
// RULE15 - bus timeout codes, arbitration policy select
// RULE16 - arbitration timeout 16 or 256 us
// RULE17 - soft local reset pulses, reads zero
// RULE18 - soft system reset pulses, reads zero
// RULE19 - PCI no local reset; VME no system reset
// RULE20 - isolation flag strapped, writable, IRQ1 triggered
// RULE21 - system reset trigger, own logic untouched
// RULE22 - auto slot-ID: IRQ2, SYSFAIL release, CR/CSR
// RULE23 - system controller flag strapped, writable
// RULE24 - read-only writes ignored, reserved read zero
`timescale 1ns/1ps
`default_nettype none
module bridge_ctl_regs
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    bridge_ctl_if.dev         bus,
    input  wire logic         i_strap_isolation,
    input  wire logic         i_strap_sys_ctrl,
    input  wire logic         i_strap_auto_id,
    input  wire logic         i_bus_owned,
    input  wire logic         i_xfer_end,
    input  wire logic         i_pw_dequeuing,
    input  wire logic [12:0]  i_pw_bytes,
    input  wire logic [7:0]   i_cfg_addr_bus,
    input  wire logic         i_irq1_asserted,
    input  wire logic         i_irq2_ack_done,
    output logic              o_retry_forever,
    output logic [9:0]        o_retry_limit,
    output logic              o_early_release,
    output logic [1:0]        o_request_level,
    output logic              o_request_fairness_sel,
    output logic              o_release_policy,
    output logic              o_bus_hold_request,
    output logic [8:0]        o_burst_bytes,
    output logic              o_cfg_type0,
    output logic [16:0]       o_bus_timeout_cycles,
    output logic              o_arbitration_policy,
    output logic [16:0]       o_arb_timeout_cycles,
    output logic              o_local_reset_out,
    output logic              o_vme_reset_out,
    output logic              o_isolation_flag,
    output logic              o_system_controller_flag,
    output logic              o_irq2_request,
    output logic              o_sysfail_released,
    output logic              o_crcsr_enable
);
    typedef struct packed {
        logic [3:0]  retry_limit;
        logic [3:0]  tenure;
        logic [1:0]  req_level;
        logic        fairness;
        logic        release_policy;
        logic        hold_req;
        logic [1:0]  burst;
        logic [7:0]  bus_no;
        logic [3:0]  bus_to;
        logic        arb_policy;
        logic [1:0]  arb_to;
        logic        isolation;
        logic        global_iso_en;
        logic        rescind;
        logic        sys_ctrl;
        logic        auto_id;
        logic        straps_taken;
        logic        local_rst_pulse;
        logic        sysrst_pulse;
        bridge_ctl_pkg::auto_state_t auto_st;
        logic [31:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic   hold_granted;
    logic   wr_mc;
    logic   wr_misc;
    logic   auto_start;

    // Granted only while the bus is owned because of the hold bit
    assign hold_granted = s_reg.hold_req & i_bus_owned;  // RULE8
    assign wr_mc   = bus.wr && (bus.addr == bridge_ctl_pkg::MASTER_CONTROL_ADDR);
    assign wr_misc = bus.wr && (bus.addr == bridge_ctl_pkg::MISC_CONTROL_ADDR);
    assign auto_start = wr_misc && bus.wdata[bridge_ctl_pkg::AUTO_ID_BIT];

    // Next state: register writes, strap capture, auto-ID sequence
    always_comb
    begin
        s_next = s_reg;
        s_next.local_rst_pulse = 1'b0;
        s_next.sysrst_pulse = 1'b0;
        // Straps are caught one cycle after reset, never under it
        if (!s_reg.straps_taken)
        begin
            s_next.straps_taken = 1'b1;
            s_next.isolation    = i_strap_isolation;  // RULE20
            s_next.sys_ctrl     = i_strap_sys_ctrl;   // RULE23
            s_next.auto_id      = i_strap_auto_id;    // RULE22
        end
        if (wr_mc)
        begin
            s_next.retry_limit    = bus.wdata[bridge_ctl_pkg::RETRY_LIMIT_LSB +: 4];
            s_next.tenure         = bus.wdata[bridge_ctl_pkg::TENURE_LSB +: 4];
            s_next.req_level      = bus.wdata[bridge_ctl_pkg::REQ_LEVEL_LSB +: 2];
            s_next.fairness       = bus.wdata[bridge_ctl_pkg::FAIRNESS_BIT];
            s_next.release_policy = bus.wdata[bridge_ctl_pkg::RELEASE_BIT];
            s_next.hold_req       = bus.wdata[bridge_ctl_pkg::HOLD_REQ_BIT];  // RULE7
            s_next.burst          = bus.wdata[bridge_ctl_pkg::BURST_LSB +: 2];
            s_next.bus_no         = bus.wdata[bridge_ctl_pkg::BUS_NO_LSB +: 8];
        end
        else if (wr_misc)
        begin
            s_next.bus_to        = bus.wdata[bridge_ctl_pkg::BUS_TO_LSB +: 4];
            s_next.arb_policy    = bus.wdata[bridge_ctl_pkg::ARB_POLICY_BIT];
            s_next.arb_to        = bus.wdata[bridge_ctl_pkg::ARB_TO_LSB +: 2];
            s_next.local_rst_pulse = bus.wdata[bridge_ctl_pkg::LOCAL_RST_BIT];  // RULE17
            s_next.sysrst_pulse  = bus.wdata[bridge_ctl_pkg::SOFT_SYSRST_BIT]
                                 | bus.wdata[bridge_ctl_pkg::SYSRST_TRIG_BIT];  // RULE18 RULE21
            s_next.isolation     = bus.wdata[bridge_ctl_pkg::ISOLATION_BIT];
            s_next.global_iso_en = bus.wdata[bridge_ctl_pkg::GLOBAL_ISO_BIT];
            s_next.rescind       = bus.wdata[bridge_ctl_pkg::RESCIND_BIT];
            s_next.sys_ctrl      = bus.wdata[bridge_ctl_pkg::SYS_CTRL_BIT];  // RULE23
            if (auto_start)
            begin
                s_next.auto_id = 1'b1;  // Writing zero has no effect
            end
        end
        // Trigger wins over a same-cycle software clear
        if (s_reg.global_iso_en && i_irq1_asserted)
        begin
            s_next.isolation = 1'b1;  // RULE20
        end
        // Auto slot-ID: raise level 2, release SYSFAIL, wait for ack
        case (s_reg.auto_st)
            bridge_ctl_pkg::AUTO_IDLE:
            begin
                if (s_reg.auto_id && s_reg.straps_taken)
                begin
                    s_next.auto_st = bridge_ctl_pkg::AUTO_IRQ;  // RULE22
                end
            end
            bridge_ctl_pkg::AUTO_IRQ:
            begin
                s_next.auto_st = bridge_ctl_pkg::AUTO_WAIT;
            end
            bridge_ctl_pkg::AUTO_WAIT:
            begin
                if (i_irq2_ack_done)
                begin
                    s_next.auto_st = bridge_ctl_pkg::AUTO_DONE;  // RULE22
                end
            end
            default:
            begin
                s_next.auto_st = bridge_ctl_pkg::AUTO_DONE;
            end
        endcase
        // Read data one cycle later; reserved and pulse bits read 0
        s_next.rdata = '0;  // RULE24
        if (bus.rd && bus.addr == bridge_ctl_pkg::MASTER_CONTROL_ADDR)
        begin
            s_next.rdata[bridge_ctl_pkg::RETRY_LIMIT_LSB +: 4] = s_reg.retry_limit;
            s_next.rdata[bridge_ctl_pkg::TENURE_LSB +: 4]      = s_reg.tenure;
            s_next.rdata[bridge_ctl_pkg::REQ_LEVEL_LSB +: 2]   = s_reg.req_level;
            s_next.rdata[bridge_ctl_pkg::FAIRNESS_BIT]         = s_reg.fairness;
            s_next.rdata[bridge_ctl_pkg::RELEASE_BIT]          = s_reg.release_policy;
            s_next.rdata[bridge_ctl_pkg::HOLD_REQ_BIT]         = s_reg.hold_req;
            s_next.rdata[bridge_ctl_pkg::HOLD_GRANTED_BIT]     = hold_granted;  // RULE8
            s_next.rdata[bridge_ctl_pkg::BURST_LSB +: 2]       = s_reg.burst;
            s_next.rdata[bridge_ctl_pkg::BUS_NO_LSB +: 8]      = s_reg.bus_no;
        end
        else if (bus.rd && bus.addr == bridge_ctl_pkg::MISC_CONTROL_ADDR)
        begin
            s_next.rdata[bridge_ctl_pkg::BUS_TO_LSB +: 4]  = s_reg.bus_to;
            s_next.rdata[bridge_ctl_pkg::ARB_POLICY_BIT]   = s_reg.arb_policy;
            s_next.rdata[bridge_ctl_pkg::ARB_TO_LSB +: 2]  = s_reg.arb_to;
            s_next.rdata[bridge_ctl_pkg::ISOLATION_BIT]    = s_reg.isolation;
            s_next.rdata[bridge_ctl_pkg::GLOBAL_ISO_BIT]   = s_reg.global_iso_en;
            s_next.rdata[bridge_ctl_pkg::RESCIND_BIT]      = s_reg.rescind;
            s_next.rdata[bridge_ctl_pkg::SYS_CTRL_BIT]     = s_reg.sys_ctrl;
            s_next.rdata[bridge_ctl_pkg::AUTO_ID_BIT]      = s_reg.auto_id;
        end
    end

    // State register, every field to its documented reset value
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_reg                <= '0;
            s_reg.retry_limit    <= bridge_ctl_pkg::RETRY_LIMIT_RST;  // RULE1
            s_reg.tenure         <= bridge_ctl_pkg::TENURE_RST;
            s_reg.req_level      <= bridge_ctl_pkg::REQ_LEVEL_RST;    // RULE4
            s_reg.bus_to         <= bridge_ctl_pkg::BUS_TO_RST;       // RULE15
            s_reg.arb_to         <= bridge_ctl_pkg::ARB_TO_RST;       // RULE16
            s_reg.rescind        <= 1'b1;
            s_reg.auto_st        <= bridge_ctl_pkg::AUTO_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Decoded controls for the bridge datapath
    assign o_retry_forever  = (s_reg.retry_limit == bridge_ctl_pkg::RETRY_FOREVER);  // RULE1
    assign o_retry_limit    = {s_reg.retry_limit, 6'h00};  // RULE1
    assign o_request_level  = s_reg.req_level;       // RULE4
    assign o_request_fairness_sel = s_reg.fairness;  // RULE5
    assign o_release_policy = s_reg.release_policy;  // RULE6
    assign o_bus_hold_request = s_reg.hold_req;      // RULE7
    assign o_burst_bytes    = bridge_ctl_pkg::BURST_BASE_BYTES << s_reg.burst;  // RULE13
    assign o_cfg_type0      = (i_cfg_addr_bus == s_reg.bus_no);  // RULE14
    assign o_arbitration_policy = s_reg.arb_policy;  // RULE15
    assign o_local_reset_out  = s_reg.local_rst_pulse;  // RULE17
    assign o_vme_reset_out    = s_reg.sysrst_pulse;  // RULE18 RULE21
    assign o_isolation_flag = s_reg.isolation;
    assign o_system_controller_flag = s_reg.sys_ctrl;
    assign o_irq2_request     = (s_reg.auto_st == bridge_ctl_pkg::AUTO_IRQ);
    assign o_sysfail_released = (s_reg.auto_st == bridge_ctl_pkg::AUTO_WAIT)
                              | (s_reg.auto_st == bridge_ctl_pkg::AUTO_DONE);
    assign o_crcsr_enable     = (s_reg.auto_st == bridge_ctl_pkg::AUTO_DONE);
    assign bus.rdata          = s_reg.rdata;
    assign bus.hold_granted   = hold_granted;

    // Early release: tenure reached or every transaction; hold overrides
    always_comb
    begin
        o_early_release = 1'b0;
        if (!s_reg.hold_req)  // RULE9
        begin
            if (s_reg.tenure == bridge_ctl_pkg::TENURE_EARLY)
            begin
                o_early_release = i_xfer_end;  // RULE3
            end
            else if (s_reg.tenure <= bridge_ctl_pkg::TENURE_MAX_CODE)
            begin
                o_early_release = i_pw_dequeuing
                    && (i_pw_bytes >= (bridge_ctl_pkg::TENURE_BASE_BYTES
                                       << s_reg.tenure));  // RULE2 RULE3
            end
        end
    end

    // Timeout codes to cycle counts; reserved codes disable
    always_comb
    begin
        o_bus_timeout_cycles = '0;
        if (s_reg.bus_to != 4'h0 && s_reg.bus_to <= bridge_ctl_pkg::BUS_TO_MAX_CODE)
        begin
            o_bus_timeout_cycles = 17'(bridge_ctl_pkg::BUS_TO_BASE_CYC)
                                   << (s_reg.bus_to - 4'h1);  // RULE15
        end
        o_arb_timeout_cycles = '0;
        if (s_reg.arb_to == bridge_ctl_pkg::ARB_TO_SHORT)
        begin
            o_arb_timeout_cycles = 17'(bridge_ctl_pkg::ARB_TO_SHORT_CYC);  // RULE16
        end
        else if (s_reg.arb_to == bridge_ctl_pkg::ARB_TO_LONG)
        begin
            o_arb_timeout_cycles = 17'(bridge_ctl_pkg::ARB_TO_LONG_CYC);  // RULE16
        end
    end
endmodule // bridge_ctl_regs
`default_nettype wire

// ---- tb/bridge_ctl_props.sv ----
// Checker: read-back and reserved-bit relations on the register port.
// Assumes it is wired by name to the interface between the two ends.
`timescale 1ns/1ps
`default_nettype none
module bridge_ctl_props
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] rdata,
    input  wire logic        hold_granted
);
    logic hold_seen_reg;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Shadow of the hold bit as last written through the port
    always_ff @(posedge i_clk)
        if (i_sys_rst)
            hold_seen_reg <= 1'h0;
        else if (wr && addr == 12'h400)
            hold_seen_reg <= wdata[19];
    a_master_rsvd_zero: assert property (
        rd && addr == 12'h400 |=> (rdata & 32'h0003CF00) == 32'h0)
        else $error("master reserved bits nonzero");
    a_misc_rsvd_zero: assert property (
        rd && addr == 12'h404 |=> (rdata & 32'h08E0FFFF) == 32'h0)
        else $error("misc reserved bits nonzero");
    a_unmapped_zero: assert property (
        rd && addr != 12'h400 && addr != 12'h404 |=> rdata == 32'h0)
        else $error("unmapped read nonzero");
    a_granted_reads: assert property (
        rd && addr == 12'h400 |=> rdata[18] == $past(hold_granted))
        else $error("granted bit wrong");
    a_granted_needs_hold: assert property (
        hold_granted |-> hold_seen_reg)
        else $error("granted without hold bit");
    a_master_readback: assert property (
        wr && addr == 12'h400 ##2 rd && addr == 12'h400 |=>
        (rdata & 32'hFFF830FF) == ($past(wdata, 3) & 32'hFFF830FF))
        else $error("master read-back wrong");
    a_misc_readback: assert property (
        wr && addr == 12'h404 ##2 rd && addr == 12'h404 |=>
        (rdata & 32'hF70E0000) == ($past(wdata, 3) & 32'hF70E0000))
        else $error("misc read-back wrong");
    a_rdata_idle: assert property (
        !rd |=> rdata == 32'h0)
        else $error("read data without read");
    c_hold: cover property (hold_granted);
    c_unmapped: cover property (rd && addr == 12'h7FC);
    c_wr_rd: cover property (wr && addr == 12'h404 ##2 rd);
endmodule // bridge_ctl_props
`default_nettype wire

// ---- tb/test_bridge_master_misc_control.sv ----
// Testbench: software port drives the master end, bank behind it.
// Assumes a 40 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_master_misc_control;
    logic i_clk = 1'h0, i_sys_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
    logic i_from_vme = 1'h0, i_berr = 1'h0, i_bus_owned = 1'h0;
    logic i_xfer_end = 1'h0, i_pw_dequeuing = 1'h0;
    logic [11:0] i_addr = 12'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'hF057880B, d, r;
    logic [12:0] i_pw_bytes = 13'h0;
    logic [7:0]  i_cfg_addr_bus = 8'h0;
    logic o_refused, o_retry_forever, o_early_release, o_request_fairness_sel;
    logic o_release_policy, o_bus_hold_request, o_cfg_type0, o_isolation_flag;
    logic o_arbitration_policy, o_local_reset_out, o_vme_reset_out;
    logic o_system_controller_flag, o_irq2_request, o_sysfail_released;
    logic o_crcsr_enable, i_irq1_asserted = 1'h0, i_irq2_ack_done = 1'h0;
    logic [3:0]  aid;
    logic [9:0]  o_retry_limit;
    logic [1:0]  o_request_level;
    logic [8:0]  o_burst_bytes;
    logic [16:0] o_bus_timeout_cycles, o_arb_timeout_cycles;
    logic [31:0] soft_d [5] = '{32'h00400000, 32'h00400000, 32'h00800000,
                                32'h00800000, 32'h00004000};
    logic [4:0]  soft_v = 5'h16;
    logic [2:0]  soft_e [5] = '{3'h2, 3'h1, 3'h4, 3'h1, 3'h2};
    int n_mismatch = 0, cmp_count = 0, c, k;
    bridge_ctl_if bridge_ctl_if_inst();
    // Straps fixed; auto ID started by software
    bridge_ctl_regs bridge_ctl_regs_inst (.*, .bus(bridge_ctl_if_inst),
        .i_strap_isolation(1'h1), .i_strap_sys_ctrl(1'h1),
        .i_strap_auto_id(1'h0));
    bridge_ctl_master bridge_ctl_master_inst (.*, .bus(bridge_ctl_if_inst));
    assign aid = {o_irq2_request, o_sysfail_released, o_crcsr_enable,
                  o_isolation_flag};
    bridge_ctl_props bridge_ctl_props_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .addr(bridge_ctl_if_inst.addr),
        .wdata(bridge_ctl_if_inst.wdata), .wr(bridge_ctl_if_inst.wr),
        .rd(bridge_ctl_if_inst.rd), .rdata(bridge_ctl_if_inst.rdata),
        .hold_granted(bridge_ctl_if_inst.hold_granted));
    always #12.5 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Timeout codes as cycle counts at 25 ns; reserved codes disable
    function automatic logic [16:0] exp_bto(input logic [3:0] cd);
        return (cd == 4'h0 || cd > 4'h7) ? 17'h0 : 17'h280 << (cd - 4'h1);
    endfunction
    function automatic logic [16:0] exp_arb(input logic [1:0] cd);
        return cd == 2'h1 ? 17'h280 : (cd == 2'h2 ? 17'h2800 : 17'h0);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write; returns mid-cycle after it, where pulses stand
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic vme);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_from_vme <= vme;
        i_wr <= 1'h1;
        @(posedge i_clk);
        i_wr <= 1'h0;
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clk);
        i_rd <= 1'h0;
        @(negedge i_clk);
        chk(o_rdata, e);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog: the whole sequence needs a few hundred cycles
    initial
    begin
        #500000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'h0;
        rd(12'h400, 32'h80C00000);
        rd(12'h404, 32'h31160000);
        chk(o_retry_limit, 32'h200);
        chk({o_isolation_flag, o_system_controller_flag}, 32'h3);
        chk(o_bus_timeout_cycles, 32'hA00);
        wr(12'h7FC, 32'hFFFFFFFF, 1'h0);
        rd(12'h7FC, 32'h0);
        rd(12'h400, 32'h80C00000);
        $display("reset done");
        for (k = 0; k < 24; k++)
        begin
            d = rnd() & 32'hFFF030FF;
            r = rnd();
            @(posedge i_clk);
            i_cfg_addr_bus <= k[0] ? d[7:0] : r[7:0];
            wr(12'h400, d, 1'h0);
            rd(12'h400, d);
            chk({o_retry_forever, o_retry_limit}, {d[31:28] == 4'h0, d[31:28], 6'h0});
            chk({o_request_level, o_request_fairness_sel, o_release_policy}, d[23:20]);
            chk(o_burst_bytes, 9'h020 << d[13:12]);
            chk(o_cfg_type0, i_cfg_addr_bus == d[7:0]);
        end
        $display("fields done");
        for (c = 0; c < 32; c++)
        begin
            wr(12'h400, {4'h8, c[4:1], 24'h0}, 1'h0);
            r = (32'h80 << c[4:1]) + c[0] - 1;
            @(posedge i_clk);
            i_pw_dequeuing <= 1'h1;
            i_pw_bytes <= r[12:0];
            i_xfer_end <= c[0];
            @(negedge i_clk);
            chk(o_early_release, c[0] && (c[4:1] <= 5 || c[4:1] == 15));
        end
        $display("tenure done");
        @(posedge i_clk);
        i_bus_owned <= 1'h1;
        wr(12'h400, 32'h8FC80000, 1'h0);
        chk({o_bus_hold_request, o_early_release}, 32'h2);
        rd(12'h400, 32'h8FCC0000);
        wr(12'h400, 32'h8FC80000, 1'h0);
        chk(o_refused, 1'h1);
        @(posedge i_clk);
        i_berr <= 1'h1;
        @(posedge i_clk);
        i_berr <= 1'h0;
        repeat (4) @(posedge i_clk);
        rd(12'h400, 32'h8FC00000);
        chk(o_early_release, 1'h1);
        wr(12'h400, 32'h8FC80000, 1'h1);
        chk({o_refused, o_bus_hold_request}, 32'h2);
        $display("hold done");
        for (k = 0; k < 5; k++)
        begin
            wr(12'h404, soft_d[k], soft_v[k]);
            chk({o_local_reset_out, o_vme_reset_out, o_refused}, soft_e[k]);
        end
        for (c = 0; c < 16; c++)
        begin
            d = {c[3:0], 1'h0, c[0], c[1:0], 24'h0};
            wr(12'h404, d, 1'h0);
            chk(o_bus_timeout_cycles, exp_bto(c[3:0]));
            chk({o_arbitration_policy, o_arb_timeout_cycles}, {c[0], exp_arb(c[1:0])});
            rd(12'h404, d);
        end
        $display("misc done");
        // Auto ID started by software, isolation by level-1 trigger
        wr(12'h404, 32'h00090000, 1'h0);
        @(negedge i_clk);
        chk(aid, 4'h8);
        @(negedge i_clk);
        chk(aid, 4'h4);
        @(posedge i_clk);
        i_irq2_ack_done <= 1'h1;
        i_irq1_asserted <= 1'h1;
        @(posedge i_clk);
        i_irq2_ack_done <= 1'h0;
        @(negedge i_clk);
        chk(aid, 4'h7);
        rd(12'h404, 32'h00190000);
        $display("auto ID done");
        stop_test();
    end
endmodule // test_bridge_master_misc_control
`default_nettype wire
